/* File: shared/pdtub_pkg.sv */
package pdtub_pkg;
   // ***************************************
   // register map
   // ***************************************
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] DTU_BASE_ADDR = 10'h21c;
   localparam logic [ADDR_W-1:0] DTU_STRIDE = 10'h020;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h2f0;
   localparam logic [31:0] DTU_RESET = 32'h00000000;
   localparam logic [3:0] FULL_WORD_LANES = 4'hf;

   // ***************************************
   // field layout of the update register
   // ***************************************
   localparam int DT_W = 12;
   localparam int LOW_FIELD_LSB = 16;
   localparam int HIGH_FIELD_LSB = 0;
   localparam logic [DT_W-1:0] DT_RESET = 12'h000;

   // ***************************************
   // status register layout
   // ***************************************
   localparam int STAT_SW_BIT = 16;
   localparam int STAT_HW_BIT = 17;

   // bus answer sequencer
   typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} pdtub_bus_state_t;
endpackage

/* File: shared/pdtub_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries one channel's write strobe, period boundary and active values
interface pdtub_chan_if #(parameter int DT_W = 12);
   logic wrStrobe;
   logic [DT_W-1:0] wrHigh;
   logic [DT_W-1:0] wrLow;
   logic periodStart;
   logic [DT_W-1:0] activeHigh;
   logic [DT_W-1:0] activeLow;
   logic pending;

   modport ctrl (output wrStrobe, output wrHigh, output wrLow, output periodStart,
                 input activeHigh, input activeLow, input pending);
   modport chan (input wrStrobe, input wrHigh, input wrLow, input periodStart,
                 output activeHigh, output activeLow, output pending);
endinterface
`default_nettype wire

/* File: hdl/pdtub_channel_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module pdtub_channel_buffer
   import pdtub_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // channel link to the register side
   pdtub_chan_if.chan ch
);
   import pdtub_pkg::*;

   logic [DT_W-1:0] shadowHigh;
   logic [DT_W-1:0] shadowLow;
   logic [DT_W-1:0] activeHigh;
   logic [DT_W-1:0] activeLow;
   logic pending;
   logic [DT_W-1:0] next_shadowHigh;
   logic [DT_W-1:0] next_shadowLow;
   logic [DT_W-1:0] next_activeHigh;
   logic [DT_W-1:0] next_activeLow;
   logic next_pending;

   // ***************************************
   // shadow and active next values
   // ***************************************
   // both shadow halves are written by the same strobe so a boundary never mixes two writes
   always_comb
   begin
      next_shadowHigh = shadowHigh;
      next_shadowLow = shadowLow;
      next_activeHigh = activeHigh;
      next_activeLow = activeLow;
      next_pending = pending;
      if (ch.periodStart && pending)
      begin
         next_activeHigh = shadowHigh; // RULE_03 RULE_09
         next_activeLow = shadowLow; // RULE_03 RULE_09
         next_pending = 1'b0;
      end
      // a write in the boundary cycle stays pending: set wins over clear
      if (ch.wrStrobe)
      begin
         next_shadowHigh = ch.wrHigh; // RULE_02
         next_shadowLow = ch.wrLow; // RULE_02
         next_pending = 1'b1;
      end
   end

   // register stage, frozen while the enable is low
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         shadowHigh <= DT_RESET;
         shadowLow <= DT_RESET;
         activeHigh <= DT_RESET;
         activeLow <= DT_RESET;
         pending <= 1'b0;
      end
      else if (ce)
      begin
         shadowHigh <= next_shadowHigh;
         shadowLow <= next_shadowLow;
         activeHigh <= next_activeHigh;
         activeLow <= next_activeLow;
         pending <= next_pending;
      end
   end

   assign ch.activeHigh = activeHigh;
   assign ch.activeLow = activeLow;
   assign ch.pending = pending;

   // ***************************************
   // checks
   // ***************************************
   property p_activeHeld;
      @(posedge clk_sys) disable iff (rst)
      !(ce && ch.periodStart) |=> $stable({activeHigh, activeLow});
   endproperty
   a_activeHeld: assert property (p_activeHeld) else $error("active dead time moved inside a period"); // RULE_02

   sequence s_writeTaken;
      ce && ch.wrStrobe && !ch.periodStart;
   endsequence
   sequence s_boundaryNoWrite;
      ce && ch.periodStart && !ch.wrStrobe;
   endsequence
   property p_writeThenLoad;
      @(posedge clk_sys) disable iff (rst)
      s_writeTaken ##1 s_boundaryNoWrite |=> (activeHigh == $past(shadowHigh)) && (activeLow == $past(shadowLow))
         && !pending;
   endproperty
   a_writeThenLoad: assert property (p_writeThenLoad) else $error("buffered pair not loaded at boundary"); // RULE_03

   property p_pairTogether;
      @(posedge clk_sys) disable iff (rst)
      ce && ch.wrStrobe ##1 (ce && ch.periodStart && !ch.wrStrobe)
         |=> {activeHigh, activeLow} == $past({ch.wrHigh, ch.wrLow}, 2);
   endproperty
   a_pairTogether: assert property (p_pairTogether) else $error("high and low taken from different writes"); // RULE_09
endmodule // pdtub_channel_buffer
`default_nettype wire

/* File: hdl/pdtub_dead_time_buffer.sv */
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE_01] writes to an update register are ignored while either protect-group-four flag is set.
// [RULE_02] written values sit in a shadow buffer and leave the running period's active values alone.
// [RULE_03] buffered values move to the active settings only at the start of the channel's next period.
// [RULE_04] only the low twelve bits of each sixteen-bit field are used; the upper four are ignored.
// [RULE_05] the low-side update value comes from bits 31 to 16.
// [RULE_06] the high-side update value comes from bits 15 to 0.
// [RULE_07] software keeps the low-side value between zero and the channel duty value.
// [RULE_08] software keeps the high-side value between zero and period minus duty.
// [RULE_09] high and low buffered values load together at the same boundary.
module pdtub_dead_time_buffer
   import pdtub_pkg::*;
#(
   parameter int NUM_CH = 4
)
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // avalon-mm slave
   input wire logic [pdtub_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // write protection status, same clock
   input wire logic swProtectGroup4Flag,
   input wire logic hwProtectGroup4Flag,
   // channel counter side
   input wire logic [NUM_CH-1:0] periodStart,
   output logic [NUM_CH*pdtub_pkg::DT_W-1:0] highSideDeadTimeActive,
   output logic [NUM_CH*pdtub_pkg::DT_W-1:0] lowSideDeadTimeActive,
   output logic [NUM_CH-1:0] updatePending
);
   import pdtub_pkg::*;

   pdtub_bus_state_t busState;
   pdtub_bus_state_t next_busState;
   logic [31:0] readData;
   logic [31:0] next_readData;
   logic busReq;
   logic busAccept;
   logic writeAllowed;
   logic [NUM_CH-1:0] chanHit;
   logic [NUM_CH-1:0] chanStrobe;
   logic [31:0] statusWord;
   logic [DT_W-1:0] fieldHigh;
   logic [DT_W-1:0] fieldLow;

   pdtub_chan_if #(.DT_W(DT_W)) chIf [NUM_CH] ();

   // ***************************************
   // bus handshake
   // ***************************************
   // one wait cycle: read data is prepared in the request cycle, so it is
   // a flop output by the time waitrequest drops
   assign busReq = avs_read || avs_write;
   assign busAccept = busReq && (busState == BUS_ANSWER) && ce;
   assign avs_waitrequest = busReq && !busAccept;
   assign avs_readdata = readData;

   always_comb
   begin
      next_busState = busState;
      case (busState)
         BUS_IDLE:
         begin
            if (busReq)
            begin
               next_busState = BUS_ANSWER;
            end
         end
         BUS_ANSWER:
         begin
            next_busState = BUS_IDLE;
         end
         default:
         begin
            next_busState = BUS_IDLE;
         end
      endcase
   end

   // ***************************************
   // read path
   // ***************************************
   // update registers are write-only and read as zero, like unmapped space
   always_comb
   begin
      statusWord = 32'h00000000;
      statusWord[NUM_CH-1:0] = updatePending;
      statusWord[STAT_SW_BIT] = swProtectGroup4Flag;
      statusWord[STAT_HW_BIT] = hwProtectGroup4Flag;
      next_readData = readData;
      if ((busState == BUS_IDLE) && avs_read)
      begin
         next_readData = (avs_address == STATUS_ADDR) ? statusWord : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         busState <= BUS_IDLE;
         readData <= DTU_RESET;
      end
      else if (ce)
      begin
         busState <= next_busState;
         readData <= next_readData;
      end
   end

   // ***************************************
   // write decode
   // ***************************************
   // partial-lane writes are dropped: a half-written pair could skew the two sides
   assign writeAllowed = busAccept && avs_write && (avs_byteenable == FULL_WORD_LANES)
      && !swProtectGroup4Flag && !hwProtectGroup4Flag; // RULE_01
   assign fieldLow = avs_writedata[LOW_FIELD_LSB +: DT_W]; // RULE_04 RULE_05
   assign fieldHigh = avs_writedata[HIGH_FIELD_LSB +: DT_W]; // RULE_04 RULE_06

   // ***************************************
   // per-channel buffers
   // ***************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_chan
         assign chanHit[gi] = (avs_address == ADDR_W'(DTU_BASE_ADDR + gi * DTU_STRIDE));
         assign chanStrobe[gi] = writeAllowed && chanHit[gi]; // RULE_01
         assign chIf[gi].wrStrobe = chanStrobe[gi];
         assign chIf[gi].wrHigh = fieldHigh;
         assign chIf[gi].wrLow = fieldLow;
         // counter boundary arrives on this clock, so no synchroniser
         assign chIf[gi].periodStart = periodStart[gi];
         assign highSideDeadTimeActive[gi*DT_W +: DT_W] = chIf[gi].activeHigh;
         assign lowSideDeadTimeActive[gi*DT_W +: DT_W] = chIf[gi].activeLow;
         assign updatePending[gi] = chIf[gi].pending;

         pdtub_channel_buffer u_buf
         (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .ch(chIf[gi])
         );
      end
   endgenerate

   // ***************************************
   // checks
   // ***************************************
   property p_protectBlocks;
      @(posedge clk_sys) disable iff (rst)
      (swProtectGroup4Flag || hwProtectGroup4Flag) |-> (chanStrobe == '0);
   endproperty
   a_protectBlocks: assert property (p_protectBlocks) else $error("write passed while protected"); // RULE_01

   property p_lowField;
      @(posedge clk_sys) disable iff (rst)
      (chanStrobe != '0) |-> (fieldLow == avs_writedata[27:16]);
   endproperty
   a_lowField: assert property (p_lowField) else $error("low-side field taken from wrong bits"); // RULE_05

   property p_highField;
      @(posedge clk_sys) disable iff (rst)
      (chanStrobe != '0) |-> (fieldHigh == avs_writedata[11:0]);
   endproperty
   a_highField: assert property (p_highField) else $error("high-side field taken from wrong bits"); // RULE_06

   sequence s_wideWrite;
      busAccept && avs_write && avs_byteenable == 4'hf && !swProtectGroup4Flag && !hwProtectGroup4Flag
         && avs_address == 10'h21c && !periodStart[0];
   endsequence
   property p_upperBitsIgnored;
      @(posedge clk_sys) disable iff (rst)
      s_wideWrite ##1 (ce && periodStart[0] && !chanStrobe[0])
         |=> highSideDeadTimeActive[DT_W-1:0] == $past(avs_writedata[11:0], 2);
   endproperty
   a_upperBitsIgnored: assert property (p_upperBitsIgnored) else $error("upper field bits reached the active value"); // RULE_04

   // a strobe must come from one full accepted word, never from a stray decode
   property p_strobeNeedsFullWord;
      @(posedge clk_sys) disable iff (rst)
      (chanStrobe != '0) |-> busAccept && avs_write && (avs_byteenable == FULL_WORD_LANES) && $onehot(chanStrobe);
   endproperty
   a_strobeNeedsFullWord: assert property (p_strobeNeedsFullWord) else $error("stray update strobe"); // RULE_01

   // with the enable low nothing moves, not even on a boundary in that cycle
   property p_frozenWithoutEnable;
      @(posedge clk_sys) disable iff (rst)
      !ce |=> $stable({highSideDeadTimeActive, lowSideDeadTimeActive, updatePending});
   endproperty
   a_frozenWithoutEnable: assert property (p_frozenWithoutEnable) else $error("moved while enable low"); // RULE_02

   // ***************************************
   // per-channel bookkeeping checks
   // ***************************************
   // software polls the pending flag, so it must track the shadow exactly
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_chk
         sequence s_acceptedWrite;
            ce && chanStrobe[gi];
         endsequence
         sequence s_loadingBoundary;
            ce && periodStart[gi] && updatePending[gi] && !chanStrobe[gi];
         endsequence
         property p_writeMarksPending;
            @(posedge clk_sys) disable iff (rst)
            s_acceptedWrite |=> updatePending[gi];
         endproperty
         a_writeMarksPending: assert property (p_writeMarksPending) // RULE_02
            else $error("no pending mark");

         property p_boundaryClearsPending;
            @(posedge clk_sys) disable iff (rst)
            s_loadingBoundary |=> !updatePending[gi];
         endproperty
         a_boundaryClearsPending: assert property (p_boundaryClearsPending) // RULE_03
            else $error("pending kept after load");
      end
   endgenerate
endmodule // pdtub_dead_time_buffer
`default_nettype wire

/* File: verification/pdtub_period_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ***
// channel counter stand-in
// ***
module pdtub_period_model #(
   parameter int NUM_CH = 4
)
(
   // clock, reset
   input wire logic clk_sys,
   input wire logic rst,
   // boundary request from the bench
   input wire logic fire,
   input wire logic [1:0] chSel,
   // period boundaries toward the buffer
   output logic [NUM_CH-1:0] periodStart
);
   // one-cycle pulse, low between boundaries so a boundary loads once
   always_ff @(posedge clk_sys)
   begin
      periodStart <= (rst || !fire) ? '0 : NUM_CH'(1) << chSel;
   end
endmodule // pdtub_period_model
`default_nettype wire

/* File: verification/pwm_dead_time_update_buffer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_dead_time_update_buffer_tb;
   import pdtub_pkg::*;
   // ***
   // bench
   // ***
   localparam int DUTY = 12'h300;
   localparam int PERIOD = 12'h800;
   logic clk_sys, rst, ce, avs_read, avs_write, fire, swFlag, hwFlag, startSeen, peekNow, avs_waitrequest;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rnd;
   logic [3:0] avs_byteenable, periodStart, updatePending, pend;
   logic [1:0] chSel;
   logic [47:0] highAct, lowAct;
   logic [11:0] actH [4], actL [4], shH [4], shL [4];
   logic [31:0] notes [$];
   int errors, comparisons;

   pdtub_dead_time_buffer #(.NUM_CH(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .swProtectGroup4Flag(swFlag),
      .hwProtectGroup4Flag(hwFlag), .periodStart(periodStart), .highSideDeadTimeActive(highAct),
      .lowSideDeadTimeActive(lowAct), .updatePending(updatePending));
   pdtub_period_model #(.NUM_CH(4)) far_u (.clk_sys(clk_sys), .rst(rst), .fire(fire), .chSel(chSel),
      .periodStart(periodStart));

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got);
      logic [31:0] want;
      want = (notes.size() > 0) ? notes.pop_front() : ~got;
      comparisons++;
      if (want !== got)
      begin
         errors++;
         $display("[ERR] t=%0t want=%h got=%h", $time, want, got);
      end
   endtask

   // results are checked where they appear, against the oldest note
   always @(posedge clk_sys)
   begin
      if (avs_read && avs_waitrequest === 1'b0)
         check(avs_readdata);
      if (startSeen || peekNow)
         check({4'h0, lowAct[chSel*12 +: 12], 4'h0, highAct[chSel*12 +: 12]});
      startSeen <= |periodStart;
   end

   // one access; the request stands until waitrequest is seen low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge clk_sys);
      end
      if (n == 50)
         errors++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask

   // upper nibbles random: they must be dropped
   task automatic wr(input int ch, input logic [3:0] be);
      logic [11:0] h, l;
      l = 12'($urandom % (DUTY + 1));
      h = 12'($urandom % (PERIOD - DUTY + 1));
      bus(1'b1, DTU_BASE_ADDR + 10'(ch) * DTU_STRIDE, {4'($urandom), l, 4'($urandom), h}, be);
      if (!swFlag && !hwFlag && be == FULL_WORD_LANES)
      begin
         shH[ch] = h;
         shL[ch] = l;
         pend[ch] = 1'b1;
      end
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      notes.push_back(e);
      bus(1'b0, a, 32'h0, FULL_WORD_LANES);
   endtask

   task automatic rdStatus();
      logic [31:0] e;
      e = {28'h0, pend};
      e[STAT_SW_BIT] = swFlag;
      e[STAT_HW_BIT] = hwFlag;
      rd(STATUS_ADDR, e);
   endtask

   task automatic peek(input int ch);
      notes.push_back({4'h0, actL[ch], 4'h0, actH[ch]});
      chSel <= 2'(ch);
      peekNow <= 1'b1;
      @(posedge clk_sys);
      peekNow <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic boundary(input int ch);
      if (pend[ch])
      begin
         actH[ch] = shH[ch];
         actL[ch] = shL[ch];
         pend[ch] = 1'b0;
      end
      notes.push_back({4'h0, actL[ch], 4'h0, actH[ch]});
      chSel <= 2'(ch);
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // write taken one cycle before the boundary: the fresh pair loads at once
   task automatic wrThenBoundary(input int ch);
      fork
         wr(ch, FULL_WORD_LANES);
         begin
            chSel <= 2'(ch);
            @(posedge clk_sys);
            fire <= 1'b1;
            @(posedge clk_sys);
            fire <= 1'b0;
         end
      join
      actH[ch] = shH[ch];
      actL[ch] = shL[ch];
      pend[ch] = 1'b0;
      notes.push_back({4'h0, actL[ch], 4'h0, actH[ch]});
      repeat (2) @(posedge clk_sys);
   endtask

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      summarize();
   end

   initial
   begin
      rnd = $urandom(32'hdd6a14b6);
      {rst, ce, avs_read, avs_write, fire, swFlag, hwFlag, peekNow} = 8'hc0;
      {avs_address, avs_writedata, avs_byteenable, chSel, pend} = '0;
      for (int i = 0; i < 4; i++)
         {actH[i], actL[i], shH[i], shL[i]} = '0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rdStatus();
      boundary(0);
      rd(DTU_BASE_ADDR, 32'h0);
      rd(10'h3fc, 32'h0);
      $display("test reset done");
      // second write replaces both halves before the boundary
      for (int c = 0; c < 4; c++)
      begin
         wr(c, FULL_WORD_LANES);
         boundary(c);
         wr(c, FULL_WORD_LANES);
         wr(c, FULL_WORD_LANES);
         peek(c);
         rdStatus();
         boundary(c);
         boundary(c);
         wrThenBoundary(c);
      end
      $display("test load done");
      // enable low: the boundary pulse is lost and the pair stays pending
      wr(1, FULL_WORD_LANES);
      notes.push_back({4'h0, actL[1], 4'h0, actH[1]});
      {ce, fire, chSel} <= {1'b0, 1'b1, 2'd1};
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ce <= 1'b1;
      rdStatus();
      boundary(1);
      $display("test enable done");
      for (int f = 1; f < 4; f++)
      begin
         swFlag <= f[0];
         hwFlag <= f[1];
         @(posedge clk_sys);
         wr(f, FULL_WORD_LANES);
         rdStatus();
         swFlag <= 1'b0;
         hwFlag <= 1'b0;
         boundary(f);
      end
      $display("test protect done");
      // partial lanes and unmapped writes are dropped
      wr(2, 4'h7);
      bus(1'b1, 10'h100, 32'hffffffff, FULL_WORD_LANES);
      rdStatus();
      boundary(2);
      $display("test refuse done");
      summarize();
   end
endmodule // pwm_dead_time_update_buffer_tb
`default_nettype wire
